// File: rtl/code_flash_front.sv
// code flash read cache and program/erase sequencer
//
// Functional notes
// - 256-byte cache, 8 ways, 16-byte lines
// - miss evicts least recently used way
// - cache hit answers in one cycle
// - miss latency follows core clock rate
// - commands written to command area
// - program writes one 128-byte unit
// - erase works on whole blocks only
// - fetch allowed while operation suspended
// - resume continues suspended operation
// - interrupts stay possible during self-programming
// - startup area selects block 0 or 1
// - trusted blocks unreadable when protection active
// - 16-byte unique id in four registers
// - entry bit 0 with key bits 15:8
// - access violation flag at status bit 7
// - violation interrupt gated by enable bit 7
//
// The strobed register port and the register offsets were decided locally.
`timescale 1ns/10ps
module code_flash_front
  import flash_ctl_pkg::*;
#(
  parameter logic [127:0] UNIQUE_ID = 128'h0f1e2d3c4b5a69788796a5b4c3d2e1f0 // arbitrary value
)
(
  // clock and reset
  input  wire logic               core_clk,
  input  wire logic               rst_n,
  // register port
  input  wire logic [7:0]         regAddr,
  input  wire logic [31:0]        regWdata,
  input  wire logic               regWr,
  input  wire logic               regRd,
  output logic      [31:0]        regRdata,
  // code fetch
  input  wire logic               fetchReq,
  input  wire logic [ADDR_W-1:0]  fetchAddr,
  output logic                    fetchValid,
  output logic      [31:0]        fetchData,
  // array read
  output logic      [ADDR_W-5:0]  arrLineAddr,
  input  wire logic [127:0]       arrLine,
  // array program/erase
  output logic                    peRun,
  output logic                    peProgram,
  output logic      [ADDR_W-1:0]  peAddr,
  input  wire logic [4:0]         peDataIdx,
  output logic      [31:0]        peData,
  input  wire logic               peDone,
  // protection and interrupt
  input  wire logic               tmActive,
  output logic                    violIrq
);

  // ==========================================================
  // state
  pe_state_t          peState_reg, peState_next;
  logic               viol_reg, viol_next;
  logic               irqEn_reg, irqEn_next;
  logic               entry_reg, entry_next;
  logic               cacheEn_reg, cacheEn_next;
  logic               bootSel_reg, bootSel_next;
  logic [ADDR_W-1:0]  cmdAddr_reg, cmdAddr_next;
  logic [5:0]         bufCnt_reg, bufCnt_next;
  logic [31:0]        progBuf [PROG_WORDS];
  logic               bufWr;
  logic [31:0]        rdata_next;
  logic [31:0]        peData_next;
  logic               peProgram_next;
  logic [ADDR_W-1:0]  peAddr_next;
  logic               irq_next;
  logic               invNow;
  logic               cmdViol;
  logic               fetchViol;
  logic [5:0]         regIdx;
  logic               regHit;

  fetch_state_t       fState_reg, fState_next;
  logic [1:0]         cnt_reg, cnt_next;
  logic [ADDR_W-1:0]  fAddr_reg, fAddr_next;
  logic               fValid_next;
  logic [31:0]        fData_next;
  logic [ADDR_W-5:0]  lineAddr_next;
  logic               lineValid_reg [LINES];
  logic               lineValid_next [LINES];
  logic [TAG_W-1:0]   tag_reg [LINES];
  logic [TAG_W-1:0]   tag_next [LINES];
  logic [2:0]         age_reg [LINES];
  logic [2:0]         age_next [LINES];
  logic [127:0]       lineMem [LINES];
  logic               fillEn;
  logic [3:0]         fillIdx;
  logic [WAYS-1:0]    hitVec;
  logic [ADDR_W-1:0]  mAddr;
  logic [2:0]         hitWay;
  logic [2:0]         victim;
  logic               hit;

  // ==========================================================
  // helpers
  function automatic logic [ADDR_W-1:0] mapBoot(input logic [ADDR_W-1:0] a, input logic sel);
    logic [ADDR_W-1:0] r;
    r = a;
    if (sel && (a[ADDR_W-1:BLOCK_BITS+1] == '0))
      r[BLOCK_BITS] = ~a[BLOCK_BITS];
    return r;
  endfunction

  function automatic logic [31:0] wordOf(input logic [127:0] l, input logic [1:0] w);
    return l[{w, 5'h00} +: 32];
  endfunction

  assign regIdx = regAddr[7:2];
  assign regHit = (regAddr[1:0] == 2'h0);
  assign invNow = regWr && regHit && (regIdx == IDX_CACHE_IV) && regWdata[0];
  assign mAddr  = mapBoot(fetchAddr, bootSel_reg);

  // ==========================================================
  // register file and sequencer
  always_comb
  begin
    peState_next   = peState_reg;
    viol_next      = viol_reg;
    irqEn_next     = irqEn_reg;
    entry_next     = entry_reg;
    cacheEn_next   = cacheEn_reg;
    bootSel_next   = bootSel_reg;
    cmdAddr_next   = cmdAddr_reg;
    bufCnt_next    = bufCnt_reg;
    peProgram_next = peProgram;
    peAddr_next    = peAddr;
    bufWr          = 1'b0;
    cmdViol        = 1'b0;
    rdata_next     = 32'h00000000;
    if (peState_reg == PE_RUN && peDone)
    begin
      peState_next = PE_IDLE;
      bufCnt_next  = 6'h00;
    end
    if (regWr && regHit)
    begin
      case (regIdx)
        IDX_STATUS:   if (!regWdata[VIOL_BIT]) viol_next = 1'b0;
        IDX_IRQ_EN:   irqEn_next = regWdata[IRQEN_BIT];
        IDX_ENTRY:    if (regWdata[KEY_LSB +: 8] == ENTRY_KEY) entry_next = regWdata[ENTRY_BIT];
        IDX_CACHE_EN: cacheEn_next = regWdata[0];
        IDX_BOOT_SEL: bootSel_next = regWdata[0];
        IDX_CMD_ADDR: cmdAddr_next = regWdata[ADDR_W-1:0];
        IDX_CMD_DATA:
        begin
          bufWr = (bufCnt_reg < 6'(PROG_WORDS));
          if (bufWr) bufCnt_next = bufCnt_reg + 6'h01;
        end
        IDX_CMD:
        begin
          if (!entry_reg)
            cmdViol = 1'b1;
          else
          begin
            case (regWdata[7:0])
              CMD_PROGRAM:
                if (peState_reg == PE_IDLE && bufCnt_reg == 6'(PROG_WORDS))
                begin
                  peState_next   = PE_RUN;
                  peProgram_next = 1'b1;
                  peAddr_next    = {cmdAddr_reg[ADDR_W-1:7], 7'h00};
                end
                else
                  cmdViol = 1'b1;
              CMD_ERASE:
                if (peState_reg == PE_IDLE)
                begin
                  peState_next   = PE_RUN;
                  peProgram_next = 1'b0;
                  peAddr_next    = {cmdAddr_reg[ADDR_W-1:BLOCK_BITS], {BLOCK_BITS{1'b0}}};
                end
                else
                  cmdViol = 1'b1;
              CMD_SUSPEND:
                if (peState_reg == PE_RUN) peState_next = PE_SUSP;
                else cmdViol = 1'b1;
              CMD_RESUME:
                if (peState_reg == PE_SUSP) peState_next = PE_RUN;
                else cmdViol = 1'b1;
              default: cmdViol = 1'b1;
            endcase
          end
        end
        default: ;
      endcase
    end
    if (cmdViol || fetchViol)
      viol_next = 1'b1;
    irq_next = viol_next && irqEn_next;
    if (regRd && regHit)
    begin
      case (regIdx)
        IDX_STATUS:   rdata_next[VIOL_BIT] = viol_reg;
        IDX_IRQ_EN:   rdata_next[IRQEN_BIT] = irqEn_reg;
        IDX_ENTRY:    rdata_next[ENTRY_BIT] = entry_reg;
        IDX_CACHE_EN: rdata_next[0] = cacheEn_reg;
        IDX_BOOT_SEL: rdata_next[0] = bootSel_reg;
        IDX_CMD_ADDR: rdata_next[ADDR_W-1:0] = cmdAddr_reg;
        IDX_PE_STAT:  rdata_next = {23'h000000, bufCnt_reg, peState_reg};
        IDX_UID0, IDX_UID0 + 6'h01, IDX_UID0 + 6'h02, IDX_UID0 + 6'h03:
          rdata_next = wordOf(UNIQUE_ID, 2'(regIdx - IDX_UID0));
        default: ;
      endcase
    end
    peData_next = progBuf[peDataIdx];
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      peState_reg <= PE_IDLE;
      viol_reg    <= 1'b0;
      irqEn_reg   <= 1'b0;
      entry_reg   <= 1'b0;
      cacheEn_reg <= 1'b1;
      bootSel_reg <= 1'b0;
      cmdAddr_reg <= '0;
      bufCnt_reg  <= 6'h00;
      regRdata    <= 32'h00000000;
      peData      <= 32'h00000000;
      peProgram   <= 1'b0;
      peAddr      <= '0;
      peRun       <= 1'b0;
      violIrq     <= 1'b0;
    end
    else
    begin
      peState_reg <= peState_next;
      viol_reg    <= viol_next;
      irqEn_reg   <= irqEn_next;
      entry_reg   <= entry_next;
      cacheEn_reg <= cacheEn_next;
      bootSel_reg <= bootSel_next;
      cmdAddr_reg <= cmdAddr_next;
      bufCnt_reg  <= bufCnt_next;
      regRdata    <= rdata_next;
      peData      <= peData_next;
      peProgram   <= peProgram_next;
      peAddr      <= peAddr_next;
      peRun       <= (peState_next == PE_RUN);
      violIrq     <= irq_next;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (bufWr)
      progBuf[bufCnt_reg[4:0]] <= regWdata;
    if (fillEn)
      lineMem[fillIdx] <= arrLine;
  end

  // ==========================================================
  // cache lookup
  genvar gw;
  generate
    for (gw = 0; gw < WAYS; gw++)
    begin : g_way
      assign hitVec[gw] = lineValid_reg[{mAddr[4], 3'(gw)}] && !invNow && cacheEn_reg
                          && (tag_reg[{mAddr[4], 3'(gw)}] == mAddr[ADDR_W-1:5]);
    end
  endgenerate

  always_comb
  begin
    hitWay = 3'h0;
    victim = 3'h0;
    for (int w = WAYS - 1; w >= 0; w--)
    begin
      if (hitVec[w]) hitWay = 3'(w);
      if (age_reg[{fAddr_reg[4], 3'(w)}] == 3'h7) victim = 3'(w);
    end
    for (int w = WAYS - 1; w >= 0; w--)
      if (!lineValid_reg[{fAddr_reg[4], 3'(w)}]) victim = 3'(w);
  end

  assign hit = |hitVec;

  // ==========================================================
  // fetch path
  always_comb
  begin
    fState_next   = fState_reg;
    cnt_next      = cnt_reg;
    fAddr_next    = fAddr_reg;
    fValid_next   = 1'b0;
    fData_next    = fetchData;
    lineAddr_next = arrLineAddr;
    fetchViol     = 1'b0;
    fillEn        = 1'b0;
    fillIdx       = 4'h0;
    for (int i = 0; i < LINES; i++)
    begin
      lineValid_next[i] = lineValid_reg[i] && !invNow;
      tag_next[i]       = tag_reg[i];
      age_next[i]       = age_reg[i];
    end
    case (fState_reg)
      F_IDLE:
        if (fetchReq)
        begin
          if (peState_reg == PE_RUN ||
              (tmActive && (mAddr[ADDR_W-1:BLOCK_BITS] == TM_BLOCK_A ||
                            mAddr[ADDR_W-1:BLOCK_BITS] == TM_BLOCK_B)))
          begin
            fetchViol   = 1'b1;
            fValid_next = 1'b1;
            fData_next  = 32'hffffffff;
          end
          else if (hit)
          begin
            fValid_next = 1'b1;
            fData_next  = wordOf(lineMem[{mAddr[4], hitWay}], mAddr[3:2]);
            for (int w = 0; w < WAYS; w++)
              if (age_reg[{mAddr[4], 3'(w)}] < age_reg[{mAddr[4], hitWay}])
                age_next[{mAddr[4], 3'(w)}] = age_reg[{mAddr[4], 3'(w)}] + 3'h1;
            age_next[{mAddr[4], hitWay}] = 3'h0;
          end
          else
          begin
            fState_next   = F_WAIT;
            cnt_next      = MISS_CNT;
            fAddr_next    = mAddr;
            lineAddr_next = mAddr[ADDR_W-1:4];
          end
        end
      F_WAIT:
        if (cnt_reg == 2'h1)
        begin
          fState_next = F_IDLE;
          fValid_next = 1'b1;
          fData_next  = wordOf(arrLine, fAddr_reg[3:2]);
          if (cacheEn_reg && !invNow)
          begin
            fillEn  = 1'b1;
            fillIdx = {fAddr_reg[4], victim};
            lineValid_next[fillIdx] = 1'b1;
            tag_next[fillIdx]       = fAddr_reg[ADDR_W-1:5];
            for (int w = 0; w < WAYS; w++)
              if (age_reg[{fAddr_reg[4], 3'(w)}] < age_reg[fillIdx])
                age_next[{fAddr_reg[4], 3'(w)}] = age_reg[{fAddr_reg[4], 3'(w)}] + 3'h1;
            age_next[fillIdx] = 3'h0;
          end
        end
        else
          cnt_next = cnt_reg - 2'h1;
      default: fState_next = F_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fState_reg  <= F_IDLE;
      cnt_reg     <= 2'h0;
      fAddr_reg   <= '0;
      fetchValid  <= 1'b0;
      fetchData   <= 32'h00000000;
      arrLineAddr <= '0;
      for (int i = 0; i < LINES; i++)
      begin
        lineValid_reg[i] <= 1'b0;
        tag_reg[i]       <= '0;
        age_reg[i]       <= 3'(i);
      end
    end
    else
    begin
      fState_reg  <= fState_next;
      cnt_reg     <= cnt_next;
      fAddr_reg   <= fAddr_next;
      fetchValid  <= fValid_next;
      fetchData   <= fData_next;
      arrLineAddr <= lineAddr_next;
      for (int i = 0; i < LINES; i++)
      begin
        lineValid_reg[i] <= lineValid_next[i];
        tag_reg[i]       <= tag_next[i];
        age_reg[i]       <= age_next[i];
      end
    end
  end

endmodule

// File: rtl/flash_ctl_pkg.sv
// constants, register map and state types of the code flash front end
package flash_ctl_pkg;
  // ==========================================================
  // timing
  localparam int CLK_MHZ      = 40;
  localparam int MISS_CYCLES  = (CLK_MHZ <= 50) ? 1 : ((CLK_MHZ < 100) ? 2 : 3);
  localparam logic [1:0] MISS_CNT = 2'(MISS_CYCLES);
  // ==========================================================
  // geometry
  localparam int ADDR_W      = 20;
  localparam int CACHE_BYTES = 256;
  localparam int LINE_BYTES  = 16;
  localparam int WAYS        = 8;
  localparam int LINES       = CACHE_BYTES / LINE_BYTES;
  localparam int SETS        = LINES / WAYS;
  localparam int TAG_W       = ADDR_W - 5;
  localparam int PROG_BYTES  = 128;
  localparam int PROG_WORDS  = PROG_BYTES / 4;
  localparam int BLOCK_BITS  = 13;
  localparam logic [6:0] TM_BLOCK_A = 7'h08;
  localparam logic [6:0] TM_BLOCK_B = 7'h09;
  // ==========================================================
  // register word indices (byte address = 4 * index)
  localparam logic [5:0] IDX_STATUS   = 6'h00;
  localparam logic [5:0] IDX_IRQ_EN   = 6'h01;
  localparam logic [5:0] IDX_ENTRY    = 6'h02;
  localparam logic [5:0] IDX_CACHE_EN = 6'h03;
  localparam logic [5:0] IDX_CACHE_IV = 6'h04;
  localparam logic [5:0] IDX_CMD_ADDR = 6'h05;
  localparam logic [5:0] IDX_CMD      = 6'h06;
  localparam logic [5:0] IDX_CMD_DATA = 6'h07;
  localparam logic [5:0] IDX_PE_STAT  = 6'h08;
  localparam logic [5:0] IDX_BOOT_SEL = 6'h09;
  localparam logic [5:0] IDX_UID0     = 6'h0a;
  // ==========================================================
  // fields
  localparam int VIOL_BIT   = 7;
  localparam int IRQEN_BIT  = 7;
  localparam int ENTRY_BIT  = 0;
  localparam int KEY_LSB    = 8;
  localparam logic [7:0] ENTRY_KEY = 8'haa;
  // ==========================================================
  // command codes
  localparam logic [7:0] CMD_PROGRAM = 8'he8;
  localparam logic [7:0] CMD_ERASE   = 8'h20;
  localparam logic [7:0] CMD_SUSPEND = 8'hb0;
  localparam logic [7:0] CMD_RESUME  = 8'hd0;
  // ==========================================================
  // states
  typedef enum logic [2:0] {PE_IDLE = 3'b001, PE_RUN = 3'b010, PE_SUSP = 3'b100} pe_state_t;
  typedef enum logic [1:0] {F_IDLE = 2'b01, F_WAIT = 2'b10} fetch_state_t;
endpackage

// File: verification/code_flash_front_asserts.sv
// port assertions of the code flash front end
`timescale 1ns/10ps
module code_flash_front_asserts
  import flash_ctl_pkg::*;
(
  // clock and reset
  input wire logic              core_clk,
  input wire logic              rst_n,
  // register port
  input wire logic [7:0]        regAddr,
  input wire logic [31:0]       regWdata,
  input wire logic              regWr,
  input wire logic              regRd,
  input wire logic [31:0]       regRdata,
  // fetch and array
  input wire logic              fetchReq,
  input wire logic [ADDR_W-1:0] fetchAddr,
  input wire logic              fetchValid,
  input wire logic [31:0]       fetchData,
  input wire logic [ADDR_W-5:0] arrLineAddr,
  // program/erase and protection
  input wire logic              peRun,
  input wire logic              peProgram,
  input wire logic [ADDR_W-1:0] peAddr,
  input wire logic              peDone,
  input wire logic              tmActive,
  input wire logic              violIrq
);
  localparam int LAT_MAX = 1 + MISS_CYCLES;
  logic pend_reg;
  logic pend_next;
  logic en_reg;
  logic en_next;
  logic taken;
  // ==========
  // fetch tracking and enable shadow
  assign taken = fetchReq && (!pend_reg || fetchValid);
  always_comb
  begin
    pend_next = taken ? 1'b1 : (fetchValid ? 1'b0 : pend_reg);
    en_next   = en_reg;
    if (regWr && regAddr == {IDX_IRQ_EN, 2'b00})
      en_next = regWdata[IRQEN_BIT];
  end
  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n)
    begin
      pend_reg <= 1'b0;
      en_reg   <= 1'b0;
    end
    else
    begin
      pend_reg <= pend_next;
      en_reg   <= en_next;
    end
  // ==========
  // properties
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence cmdWr(code);
    regWr && regAddr == {IDX_CMD, 2'b00} && regWdata[7:0] == code;
  endsequence
  AST_RD_IDLE: assert property (!$past(regRd) |-> regRdata == 32'h0)
    else $error("read data not zero outside read cycle");
  AST_FETCH_LAT: assert property (taken |-> ##[1:LAT_MAX] fetchValid)
    else $error("fetch answer late");
  AST_FETCH_CAUSE: assert property (fetchValid |-> pend_reg)
    else $error("fetch answer without request");
  AST_MISS_LINE: assert property (fetchValid && $past(taken, 2) && !$past(taken)
    && $past(fetchAddr[19:14], 2) != 6'h00 |-> arrLineAddr == $past(fetchAddr[19:4], 2))
    else $error("miss read wrong line");
  AST_VIOL_DATA: assert property (taken && (peRun || (tmActive && (fetchAddr[19:13] == TM_BLOCK_A
    || fetchAddr[19:13] == TM_BLOCK_B))) |=> fetchValid && fetchData == 32'hffffffff)
    else $error("refused fetch not answered with erased data");
  AST_PE_START: assert property ($rose(peRun) |-> $past(regWr && regAddr == {IDX_CMD, 2'b00}))
    else $error("operation started without command");
  AST_SUSPEND: assert property (cmdWr(CMD_SUSPEND) ##0 peRun |=> !peRun)
    else $error("suspend did not stop operation");
  AST_DONE: assert property (peDone && peRun |=> !peRun)
    else $error("operation did not end on done");
  AST_PROG_UNIT: assert property (peRun && peProgram |-> peAddr[6:0] == 7'h00)
    else $error("program start not unit aligned");
  AST_ERASE_BLOCK: assert property (peRun && !peProgram |-> peAddr[12:0] == 13'h0000)
    else $error("erase start not block aligned");
  AST_IRQ_GATE: assert property (violIrq |-> en_reg)
    else $error("interrupt while disabled");
endmodule

// File: verification/flash_array_model.sv
// flash array model answering line reads and program/erase runs
`timescale 1ns/10ps
module flash_array_model
  import flash_ctl_pkg::*;
(
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  // line read
  input  wire logic [ADDR_W-5:0] arrLineAddr,
  output logic      [127:0]      arrLine,
  // program/erase
  input  wire logic              peRun,
  output logic      [4:0]        peDataIdx,
  input  wire logic [31:0]       peData,
  output logic                   peDone,
  // bench control
  input  wire logic              doneGo
);
  logic [31:0] cap [32];
  logic [5:0]  cnt_reg;
  logic [4:0]  prev_reg;
  logic        valid_reg;
  // ==========
  // line word carries its line address and index
  always_comb
    for (int n = 0; n < 4; n++)
      arrLine[32*n +: 32] = {arrLineAddr, 14'h3a5, 2'(n)};
  assign peDataIdx = cnt_reg[4:0];
  // ==========
  // one word a cycle while running, done after all 32
  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n)
    begin
      cnt_reg   <= 6'd0;
      prev_reg  <= 5'd0;
      valid_reg <= 1'b0;
      peDone    <= 1'b0;
    end
    else
    begin
      valid_reg <= peRun && cnt_reg < 6'd32;
      prev_reg  <= cnt_reg[4:0];
      if (valid_reg)
        cap[prev_reg] <= peData;
      if (peRun && cnt_reg < 6'd32)
        cnt_reg <= cnt_reg + 6'd1;
      peDone <= peRun && cnt_reg == 6'd32 && doneGo && !peDone;
      if (peDone)
        cnt_reg <= 6'd0;
    end
endmodule

// File: verification/tb_top.sv
// testbench of the code flash front end
`timescale 1ns/10ps
module tb_top import flash_ctl_pkg::*;;
  localparam logic [127:0] UID = 128'h1122334455667788_99aabbccddeeff00; // arbitrary value
  logic core_clk, rst_n, regWr, regRd, fetchReq, fetchValid, peRun, peProgram, peDone, tmActive, violIrq, doneGo;
  logic [7:0]        regAddr;
  logic [31:0]       regWdata, regRdata, fetchData, peData, rnd;
  logic [ADDR_W-1:0] fetchAddr, peAddr;
  logic [ADDR_W-5:0] arrLineAddr;
  logic [127:0]      arrLine;
  logic [4:0]        peDataIdx;
  logic [31:0]       pw [32];
  int                failures, comparisons;
  code_flash_front #(.UNIQUE_ID(UID)) i_code_flash_front (.core_clk, .rst_n, .regAddr, .regWdata, .regWr,
    .regRd, .regRdata, .fetchReq, .fetchAddr, .fetchValid, .fetchData, .arrLineAddr, .arrLine, .peRun,
    .peProgram, .peAddr, .peDataIdx, .peData, .peDone, .tmActive, .violIrq);
  flash_array_model i_flash_array_model (.core_clk, .rst_n, .arrLineAddr, .arrLine, .peRun, .peDataIdx,
    .peData, .peDone, .doneGo);
  // ==========
  // helpers
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] lw(input logic [19:0] a);
    return {a[19:4], 14'h3a5, a[3:2]};
  endfunction
  function automatic logic [19:0] la(input int k);
    return 20'h20000 + 20'(k * 32);
  endfunction
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [5:0] i, input logic [31:0] d);
    @(posedge core_clk);
    regWr    <= 1'b1;
    regAddr  <= {i, 2'b00};
    regWdata <= d;
    @(posedge core_clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] i, input logic [31:0] e);
    @(posedge core_clk);
    regRd   <= 1'b1;
    regAddr <= {i, 2'b00};
    @(posedge core_clk);
    regRd <= 1'b0;
    #1;
    chk($sformatf("register %0d", i), regRdata, e);
  endtask
  task automatic ft(input logic [19:0] a, input logic [31:0] e, input int lat);
    int n;
    @(posedge core_clk);
    fetchReq  <= 1'b1;
    fetchAddr <= a;
    @(posedge core_clk);
    fetchReq <= 1'b0;
    n = 1;
    #1;
    while (fetchValid !== 1'b1 && n < 6)
    begin
      @(posedge core_clk);
      #1;
      n++;
    end
    chk("fetch data", fetchData, e);
    chk("fetch latency", 32'(n), 32'(lat));
  endtask
  task automatic waitRun;
    int n;
    n = 0;
    while (peRun === 1'b1 && n < 200)
    begin
      @(posedge core_clk);
      #1;
      n++;
    end
    chk("pe run", 32'(peRun), 32'h0);
  endtask
  task automatic print_verdict;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // ==========
  // clock and watchdog
  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  initial
  begin
    repeat (20000) @(posedge core_clk);
    failures++;
    print_verdict;
  end
  // ==========
  // scenarios
  initial
  begin
    logic [19:0] b;
    logic [19:0] c;
    {regAddr, regWdata, regWr, regRd, fetchReq, fetchAddr, tmActive, doneGo} = '0;
    rst_n = 1'b0;
    rnd = 32'hcbe94fc0;
    failures = 0;
    comparisons = 0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(IDX_STATUS, 32'h0);
    rd(IDX_IRQ_EN, 32'h0);
    rd(IDX_ENTRY, 32'h0);
    rd(IDX_CACHE_EN, 32'h1);
    rd(IDX_PE_STAT, 32'h1);
    rd(IDX_BOOT_SEL, 32'h0);
    rd(6'h3f, 32'h0);
    for (int k = 0; k < 4; k++)
      rd(IDX_UID0 + 6'(k), UID[32*k +: 32]);
    for (int k = 0; k < 6; k++)
    begin
      rnd = nxt(rnd);
      b = {4'h3, rnd[15:4], rnd[21:20], 2'b00};
      c = {b[19:4], rnd[23:22], 2'b00};
      wr(IDX_CACHE_IV, 32'h1);
      ft(b, lw(b), 2);
      ft(c, lw(c), 1);
    end
    wr(IDX_CACHE_IV, 32'h1);
    for (int k = 0; k < 8; k++)
      ft(la(k), lw(la(k)), 2);
    ft(la(0), lw(la(0)), 1);
    ft(la(8), lw(la(8)), 2);
    ft(la(0), lw(la(0)), 1);
    ft(la(1), lw(la(1)), 2);
    wr(IDX_CACHE_EN, 32'h0);
    ft(la(0), lw(la(0)), 2);
    wr(IDX_CACHE_EN, 32'h1);
    ft(la(0), lw(la(0)), 1);
    wr(IDX_CACHE_IV, 32'h1);
    ft(la(0), lw(la(0)), 2);
    wr(IDX_ENTRY, {16'h0, ~ENTRY_KEY, 8'h01});
    rd(IDX_ENTRY, 32'h0);
    wr(IDX_CMD, {24'h0, CMD_ERASE});
    rd(IDX_PE_STAT, 32'h1);
    rd(IDX_STATUS, 32'h80);
    wr(IDX_STATUS, 32'h0);
    rd(IDX_STATUS, 32'h0);
    wr(IDX_ENTRY, {16'h0, ENTRY_KEY, 8'h01});
    rd(IDX_ENTRY, 32'h1);
    wr(IDX_CMD, {24'h0, CMD_PROGRAM});
    rd(IDX_PE_STAT, 32'h1);
    rd(IDX_STATUS, 32'h80);
    wr(IDX_STATUS, 32'h0);
    @(posedge core_clk);
    tmActive <= 1'b1;
    ft(20'h10040, 32'hffffffff, 1);
    rd(IDX_STATUS, 32'h80);
    chk("irq", 32'(violIrq), 32'h0);
    wr(IDX_IRQ_EN, 32'h80);
    @(posedge core_clk);
    #1;
    chk("irq", 32'(violIrq), 32'h1);
    wr(IDX_STATUS, 32'h0);
    @(posedge core_clk);
    tmActive <= 1'b0;
    #1;
    chk("irq", 32'(violIrq), 32'h0);
    ft(20'h10040, lw(20'h10040), 2);
    wr(IDX_CMD_ADDR, 32'h40080);
    for (int k = 0; k < 32; k++)
    begin
      rnd = nxt(rnd);
      pw[k] = rnd;
      wr(IDX_CMD_DATA, rnd);
    end
    wr(IDX_CMD, {24'h0, CMD_PROGRAM});
    #1;
    chk("pe run", 32'(peRun), 32'h1);
    chk("pe program", 32'(peProgram), 32'h1);
    chk("pe address", 32'(peAddr), 32'h40080);
    ft(la(3), 32'hffffffff, 1);
    @(posedge core_clk);
    #1;
    chk("irq", 32'(violIrq), 32'h1);
    wr(IDX_CMD, {24'h0, CMD_SUSPEND});
    @(posedge core_clk);
    #1;
    chk("pe run", 32'(peRun), 32'h0);
    rd(IDX_PE_STAT, 32'h104);
    ft(la(0), lw(la(0)), 1);
    wr(IDX_CMD, {24'h0, CMD_RESUME});
    @(posedge core_clk);
    doneGo <= 1'b1;
    #1;
    chk("pe run", 32'(peRun), 32'h1);
    waitRun;
    for (int k = 0; k < 32; k++)
      chk("program word", i_flash_array_model.cap[k], pw[k]);
    rd(IDX_PE_STAT, 32'h1);
    wr(IDX_CMD_ADDR, 32'h4e000);
    wr(IDX_CMD, {24'h0, CMD_ERASE});
    #1;
    chk("pe program", 32'(peProgram), 32'h0);
    chk("pe address", 32'(peAddr), 32'h4e000);
    waitRun;
    wr(IDX_BOOT_SEL, 32'h1);
    rd(IDX_BOOT_SEL, 32'h1);
    wr(IDX_CACHE_IV, 32'h1);
    ft(20'h00010, lw(20'h02010), 2);
    print_verdict;
  end
endmodule
bind code_flash_front code_flash_front_asserts i_asserts (.core_clk, .rst_n, .regAddr, .regWdata, .regWr,
  .regRd, .regRdata, .fetchReq, .fetchAddr, .fetchValid, .fetchData, .arrLineAddr, .peRun, .peProgram,
  .peAddr, .peDone, .tmActive, .violIrq);
